/* File: include/fracn_cfg_pkg.sv */
// constants for the fractional-n divider configuration register bank
package fracn_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CALIB_PRESCALER_CTRL = 12'h012;
  localparam logic [ADDR_W-1:0] OFS_PRIMARY_FRACTION_BYTE0 = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_PRIMARY_FRACTION_BYTE1 = 12'h015;
  localparam logic [ADDR_W-1:0] OFS_PRIMARY_FRACTION_BYTE2 = 12'h016;
  localparam logic [ADDR_W-1:0] OFS_FRACTION_SHARED_BYTE = 12'h017;
  localparam logic [ADDR_W-1:0] OFS_AUX_FRACTION_HIGH = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_AUX_MODULUS_LOW = 12'h019;
  localparam logic [ADDR_W-1:0] OFS_AUX_MODULUS_HIGH = 12'h01a;
  localparam logic [ADDR_W-1:0] OFS_SEED_BYTE0 = 12'h01b;
  localparam logic [ADDR_W-1:0] OFS_SEED_BYTE1 = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_SEED_BYTE2 = 12'h01d;
  localparam logic [ADDR_W-1:0] OFS_INTEGER_LOW = 12'h010;
  localparam int NUM_REGS = 11;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam int POS_CALIB_ON = 6;
  localparam int POS_PRESCALER_SEL = 5;
  localparam int PRIMARY_W = 25;
  localparam int AUX_W = 14;
  localparam int SEED_W = 24;
endpackage : fracn_cfg_pkg

/* File: core/fracn_byte_decode.sv */
// address to register index decoder for the configuration bank
`timescale 1ns/1ps
module fracn_byte_decode
  import fracn_cfg_pkg::*;
(
  input wire logic [fracn_cfg_pkg::ADDR_W-1:0] addr,
  output logic hit,
  output logic [3:0] index
);
  always_comb
  begin
    hit = 1'b1;
    index = 4'h0;
    if (addr == OFS_CALIB_PRESCALER_CTRL)
    begin
      index = 4'h0;
    end
    else if (addr >= OFS_PRIMARY_FRACTION_BYTE0 && addr <= OFS_SEED_BYTE2)
    begin
      // bytes 0x014..0x01d map onto indices 1..10
      index = 4'(addr - OFS_PRIMARY_FRACTION_BYTE0 + 12'h001);
    end
    else
    begin
      hit = 1'b0;
    end
  end
endmodule : fracn_byte_decode

/* File: core/fracn_divider_config_regs.sv */
// fractional-n divider configuration register bank with double-buffered fraction and modulus outputs
`timescale 1ns/1ps
//
// Contract
// - bit 6 of control register enables vco autocalibration, resets to 0
// - bit 5 selects prescaler: 0 gives 4/5, 1 gives 8/9
// - primary fraction is 25 bits over three bytes plus bit 0 of next
// - auxiliary fraction 14 bits: low 7 in shared byte 7:1, high 7 next
// - auxiliary modulus 14 bits: low byte, then bits 5:0 of next register
// - 24-bit phase seed stored little-endian over three byte registers
// - every register reads zero after reset, reserved bits included
// - fraction and modulus reach divider only on integer low byte write
module fracn_divider_config_regs
  import fracn_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [fracn_cfg_pkg::ADDR_W-1:0] ADDR,
  input wire logic [fracn_cfg_pkg::DATA_W-1:0] WDATA,
  output logic [fracn_cfg_pkg::DATA_W-1:0] RDATA,
  output logic RHIT,
  output logic VCO_CALIB_ON,
  output logic PRESCALER_8_9,
  output logic [fracn_cfg_pkg::PRIMARY_W-1:0] PRIMARY_FRACTION,
  output logic [fracn_cfg_pkg::AUX_W-1:0] AUXILIARY_FRACTION,
  output logic [fracn_cfg_pkg::AUX_W-1:0] AUXILIARY_MODULUS,
  output logic [fracn_cfg_pkg::SEED_W-1:0] PHASE_SEED
);
  import fracn_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0] rdata;
    logic rhit;
    logic [PRIMARY_W-1:0] primary_fraction;
    logic [AUX_W-1:0] auxiliary_fraction;
    logic [AUX_W-1:0] auxiliary_modulus;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  logic hit;
  logic [3:0] index;

  fracn_byte_decode u_decode (
    .addr(ADDR),
    .hit(hit),
    .index(index)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [PRIMARY_W-1:0] primary_of(input logic [NUM_REGS-1:0][DATA_W-1:0] r);
    primary_of = {r[4][0], r[3], r[2], r[1]};
  endfunction : primary_of

  function automatic logic [AUX_W-1:0] aux_frac_of(input logic [NUM_REGS-1:0][DATA_W-1:0] r);
    aux_frac_of = {r[5][6:0], r[4][7:1]};
  endfunction : aux_frac_of

  function automatic logic [AUX_W-1:0] aux_mod_of(input logic [NUM_REGS-1:0][DATA_W-1:0] r);
    aux_mod_of = {r[7][5:0], r[6]};
  endfunction : aux_mod_of

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.rhit = 1'b0;
    if (WR_EN && hit)
    begin
      // full byte kept, reserved bits too, so reads echo writes
      nxt_cur.regs[index] = WDATA;
    end
    if (RD_EN)
    begin
      nxt_cur.rhit = hit;
      // unmapped offsets answer zero
      nxt_cur.rdata = hit ? cur_ff.regs[index] : REG_RESET;
    end
    if (WR_EN && ADDR == OFS_INTEGER_LOW)
    begin
      // shadow bytes transfer together so the modulator never sees a half update
      nxt_cur.primary_fraction = primary_of(cur_ff.regs);
      nxt_cur.auxiliary_fraction = aux_frac_of(cur_ff.regs);
      nxt_cur.auxiliary_modulus = aux_mod_of(cur_ff.regs);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      cur_ff <= '0;
    end
    else if (CE)
    begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign RDATA = cur_ff.rdata;
  assign RHIT = cur_ff.rhit;
  assign VCO_CALIB_ON = cur_ff.regs[0][POS_CALIB_ON];
  assign PRESCALER_8_9 = cur_ff.regs[0][POS_PRESCALER_SEL];
  assign PRIMARY_FRACTION = cur_ff.primary_fraction;
  assign AUXILIARY_FRACTION = cur_ff.auxiliary_fraction;
  assign AUXILIARY_MODULUS = cur_ff.auxiliary_modulus;
  // seed is live: it only loads the accumulator when the loop restarts
  assign PHASE_SEED = {cur_ff.regs[10], cur_ff.regs[9], cur_ff.regs[8]};

  ////////////////////////////////////////////////////////////////////////////
  property p_reset_zero;
    @(posedge CLK) !RESETN |=> (RDATA == 8'h00 && PHASE_SEED == 24'h00_0000 && !VCO_CALIB_ON);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("bank not zero after reset");

  property p_calib_bit;
    @(posedge CLK) disable iff (!RESETN)
      (CE && WR_EN && ADDR == OFS_CALIB_PRESCALER_CTRL) |=> VCO_CALIB_ON == $past(WDATA[6]);
  endproperty
  a_calib_bit: assert property (p_calib_bit) else $error("calibration enable wrong");

  property p_presc_bit;
    @(posedge CLK) disable iff (!RESETN)
      (CE && WR_EN && ADDR == OFS_CALIB_PRESCALER_CTRL) |=> PRESCALER_8_9 == $past(WDATA[5]);
  endproperty
  a_presc_bit: assert property (p_presc_bit) else $error("prescaler select wrong");

  property p_primary_load;
    @(posedge CLK) disable iff (!RESETN)
      (CE && WR_EN && ADDR == OFS_INTEGER_LOW) |=>
        PRIMARY_FRACTION == {$past(cur_ff.regs[4][0]), $past(cur_ff.regs[3]),
                             $past(cur_ff.regs[2]), $past(cur_ff.regs[1])};
  endproperty
  a_primary_load: assert property (p_primary_load) else $error("primary fraction load");

  property p_aux_load;
    @(posedge CLK) disable iff (!RESETN)
      (CE && WR_EN && ADDR == OFS_INTEGER_LOW) |=>
        AUXILIARY_FRACTION == {$past(cur_ff.regs[5][6:0]), $past(cur_ff.regs[4][7:1])};
  endproperty
  a_aux_load: assert property (p_aux_load) else $error("aux fraction load");

  property p_mod_load;
    @(posedge CLK) disable iff (!RESETN)
      (CE && WR_EN && ADDR == OFS_INTEGER_LOW) |=>
        AUXILIARY_MODULUS == {$past(cur_ff.regs[7][5:0]), $past(cur_ff.regs[6])};
  endproperty
  a_mod_load: assert property (p_mod_load) else $error("aux modulus load");

  property p_seed_byte;
    @(posedge CLK) disable iff (!RESETN)
      (CE && WR_EN && ADDR == OFS_SEED_BYTE2) |=> PHASE_SEED[23:16] == $past(WDATA);
  endproperty
  a_seed_byte: assert property (p_seed_byte) else $error("seed high byte wrong");

  property p_shadow_hold;
    @(posedge CLK) disable iff (!RESETN)
      !(WR_EN && ADDR == OFS_INTEGER_LOW) |=> $stable(PRIMARY_FRACTION);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("fraction moved early");

  property p_readback;
    @(posedge CLK) disable iff (!RESETN)
      (CE && WR_EN && hit) ##1 (CE && RD_EN && !WR_EN && ADDR == $past(ADDR)) |=>
        RDATA == $past(WDATA, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_reset_fields;
    @(posedge CLK) !RESETN |=>
      (PRIMARY_FRACTION == 25'h000_0000 && AUXILIARY_FRACTION == 14'h0000 &&
       AUXILIARY_MODULUS == 14'h0000 && !PRESCALER_8_9 && !RHIT);
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("fields not zero after reset");

  // enable low must freeze the whole bank, read path included
  property p_ce_freeze;
    @(posedge CLK) disable iff (!RESETN)
      !CE |=> ($stable(RDATA) && $stable(RHIT) && $stable(PHASE_SEED) &&
               $stable(PRIMARY_FRACTION) && $stable(VCO_CALIB_ON));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

  property p_unmapped_read;
    @(posedge CLK) disable iff (!RESETN)
      (CE && RD_EN && !hit) |=> (!RHIT && RDATA == REG_RESET);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read answered");

  property p_rhit_pulse;
    @(posedge CLK) disable iff (!RESETN)
      (CE && !RD_EN) |=> !RHIT;
  endproperty
  a_rhit_pulse: assert property (p_rhit_pulse) else $error("read hit without read");

  property p_aux_hold;
    @(posedge CLK) disable iff (!RESETN)
      !(CE && WR_EN && ADDR == OFS_INTEGER_LOW) |=>
        ($stable(AUXILIARY_FRACTION) && $stable(AUXILIARY_MODULUS));
  endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("aux fields moved early");

  property p_seed_low;
    @(posedge CLK) disable iff (!RESETN)
      (CE && WR_EN && ADDR == OFS_SEED_BYTE0) |=> PHASE_SEED[7:0] == $past(WDATA);
  endproperty
  a_seed_low: assert property (p_seed_low) else $error("seed low byte wrong");

  property p_seed_mid;
    @(posedge CLK) disable iff (!RESETN)
      (CE && WR_EN && ADDR == OFS_SEED_BYTE1) |=> PHASE_SEED[15:8] == $past(WDATA);
  endproperty
  a_seed_mid: assert property (p_seed_mid) else $error("seed middle byte wrong");

  c_load: cover property (@(posedge CLK) CE && WR_EN && ADDR == OFS_INTEGER_LOW);
  c_read_hit: cover property (@(posedge CLK) RHIT);
  c_calib: cover property (@(posedge CLK) VCO_CALIB_ON && PRESCALER_8_9);
  c_unmapped: cover property (@(posedge CLK) CE && RD_EN && !hit);
endmodule : fracn_divider_config_regs

/* File: bench/fracn_divider_config_regs_tb_top.sv */
// self-checking bench for the divider configuration register bank
`timescale 1ns/1ps
module fracn_divider_config_regs_tb_top;
  import fracn_cfg_pkg::*;
  logic CLK, RESETN, CE, WR_EN, RD_EN, RHIT, VCO_CALIB_ON, PRESCALER_8_9;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA, RDATA;
  logic [PRIMARY_W-1:0] PRIMARY_FRACTION;
  logic [AUX_W-1:0] AUXILIARY_FRACTION, AUXILIARY_MODULUS;
  logic [SEED_W-1:0] PHASE_SEED;
  int num_errors = 0;
  int compares = 0;
  int seed = 32'hf281;
  logic [DATA_W-1:0] expq[$];
  logic [DATA_W-1:0] mem[NUM_REGS];
  logic [ADDR_W-1:0] ofs[NUM_REGS] = '{12'h012, 12'h014, 12'h015, 12'h016, 12'h017,
    12'h018, 12'h019, 12'h01a, 12'h01b, 12'h01c, 12'h01d};
  fracn_divider_config_regs u_dut (.CLK(CLK), .RESETN(RESETN), .CE(CE), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .RHIT(RHIT),
    .VCO_CALIB_ON(VCO_CALIB_ON), .PRESCALER_8_9(PRESCALER_8_9),
    .PRIMARY_FRACTION(PRIMARY_FRACTION), .AUXILIARY_FRACTION(AUXILIARY_FRACTION),
    .AUXILIARY_MODULUS(AUXILIARY_MODULUS), .PHASE_SEED(PHASE_SEED));
  ////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one strobe per call; the idle edge between calls keeps drives apart
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLK);
    #1 WR_EN = 1'b1;
    ADDR = a;
    WDATA = d;
    @(posedge CLK);
    #1 WR_EN = 1'b0;
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge CLK);
    #1 RD_EN = 1'b1;
    ADDR = a;
    expq.push_back(e);
    @(posedge CLK);
    #1 RD_EN = 1'b0;
  endtask : rd
  task check_fields;
    chk("vco_calib_on", VCO_CALIB_ON, mem[0][6]);
    chk("prescaler_8_9", PRESCALER_8_9, mem[0][5]);
    chk("primary", PRIMARY_FRACTION, {mem[4][0], mem[3], mem[2], mem[1]});
    chk("aux_fraction", AUXILIARY_FRACTION, {mem[5][6:0], mem[4][7:1]});
    chk("aux_modulus", AUXILIARY_MODULUS, {mem[7][5:0], mem[6]});
    chk("seed", PHASE_SEED, {mem[10], mem[9], mem[8]});
  endtask : check_fields
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // read results are matched in order against the expected bytes queued in expq by rd and the inline read
  always @(posedge CLK)
  begin
    #2;
    if (RHIT === 1'b1)
    begin
      if (expq.size() == 0)
        chk("unexpected_read", 32'h0000_0001, 32'h0000_0000);
      else
        chk("rdata", RDATA, expq.pop_front());
    end
  end
  initial
  begin
    repeat (5000) @(posedge CLK);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    RESETN = 1'b0;
    CE = 1'b1;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = '0;
    WDATA = '0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (3) @(posedge CLK);
    #1 RESETN = 1'b1;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    check_fields();
    foreach (ofs[i])
    begin
      mem[i] = 8'($random(seed));
      wr(ofs[i], mem[i]);
    end
    wr(12'h013, 8'hff);
    foreach (ofs[i]) rd(ofs[i], mem[i]);
    chk("primary_held", PRIMARY_FRACTION, 32'h0000_0000);
    wr(12'h010, 8'h80);
    check_fields();
    // new byte must stay in shadow until the integer low byte is written
    wr(12'h015, 8'h5a);
    check_fields();
    mem[2] = 8'h5a;
    rd(12'h015, 8'h5a);
    // unmapped read must clear the data left by the read before it
    @(posedge CLK);
    #1 RD_EN = 1'b1;
    ADDR = 12'h013;
    @(posedge CLK);
    #1 RD_EN = 1'b0;
    chk("unmapped_rhit", RHIT, 32'h0000_0000);
    chk("unmapped_rdata", RDATA, 32'h0000_0000);
    // write then read on consecutive edges, the read sees the new byte
    @(posedge CLK);
    #1 WR_EN = 1'b1;
    ADDR = 12'h017;
    WDATA = 8'($random(seed));
    mem[4] = WDATA;
    @(posedge CLK);
    #1 WR_EN = 1'b0;
    RD_EN = 1'b1;
    expq.push_back(mem[4]);
    @(posedge CLK);
    #1 RD_EN = 1'b0;
    wr(12'h010, 8'h80);
    check_fields();
    wr(12'h01b, 8'h09);
    wr(12'h01c, 8'h00);
    wr(12'h01d, 8'h80);
    chk("seed_best", PHASE_SEED, 32'h0080_0009);
    // a write presented while the enable is low must leave the bank untouched
    @(posedge CLK);
    #1 CE = 1'b0;
    wr(12'h01b, 8'h33);
    @(posedge CLK);
    #1 CE = 1'b1;
    chk("seed_frozen", PHASE_SEED, 32'h0080_0009);
    rd(12'h01b, 8'h09);
    @(posedge CLK);
    #1 RESETN = 1'b0;
    @(posedge CLK);
    #1 RESETN = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    check_fields();
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    repeat (3) @(posedge CLK);
    chk("reads_left", expq.size(), 32'h0000_0000);
    wrap_up();
  end
endmodule : fracn_divider_config_regs_tb_top
